// *** verilog/csf_status_flags.sv ***
/*
 * CPU status flag register with its update logic: arithmetic flags,
 * decimal adjust state, fast interrupt status and register page select.
 * Assumes all inputs come from the CPU core on i_clk; no synchronisers.
 */
// Contract
// - Carry marks carry-out or borrow at bit 7
// - Shifts leave last bit shifted out in carry
// - Carry can be set, cleared, or inverted
// - Zero set when result equals zero
// - Sign copies result most significant bit
// - Overflow set on two's-complement range excess
// - Logic operations always clear overflow
// - AND updates zero, sign and overflow
// - Only carry, zero, sign, overflow are conditions
// - Decimal bit zero after add, one after subtract
// - Decimal bit never a branch condition
// - Half-carry marks carry or borrow at bit 3
// - Decimal adjust corrects using half-carry, decimal bit
// - Fast status set on entry, cleared on return
// - Fast status blocks interrupts, selects fast return
// - Page ops clear or set the page bit
// - Direct writes store the written value; the code leaves bit 1 (fast status) unchanged
`timescale 1ns/1ps
module csf_status_flags
    import csf_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Operation request from the sequencer
    input  wire logic       i_op_valid,
    input  wire csf_op_t    i_op,
    input  wire logic [7:0] i_opnd_a,
    input  wire logic [7:0] i_opnd_b,
    // Operation result
    output logic [7:0]      o_result,
    output logic            o_result_wr,
    // Register file access
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_wdata,
    output logic [7:0]      o_reg_rdata,
    // Interrupt and page control
    input  wire logic       i_fast_int_start,
    input  wire logic       i_int_return,
    input  wire logic       i_sel_page0,
    input  wire logic       i_sel_page1,
    output logic            o_int_block,
    output logic            o_fast_return,
    output logic            o_page_sel,
    // Jump condition test
    input  wire csf_cond_t  i_cond,
    output logic            o_cond_true,
    // Whole register for observation
    output logic [7:0]      o_flags
);

    csf_alu_if alu_link ();          // Link to the flag calculator

    logic [7:2] arith_q;             // Carry, zero, sign, overflow, decimal, half
    logic       fis_q;               // Fast interrupt status
    logic       page_q;              // Register page select
    logic [7:0] result_q;            // Registered result
    logic       result_wr_q;         // Registered result write strobe
    logic [7:0] rdata_q;             // Registered read data
    logic       fast_ret_q;          // Fast return request pulse
    logic       addr_hit;            // Access targets the status register
    logic       op_upd;              // Live operation that changes flags
    logic       dir_wr;              // Direct write that is allowed to land
    logic [7:0] flags;               // Assembled status register

    // Assemble the register from its three owners
    assign flags    = {arith_q, fis_q, page_q};
    assign addr_hit = (i_reg_addr == CSF_STATUS_ADDR);
    assign op_upd   = i_op_valid && alu_link.upd;

    // A flag-changing operation in the same cycle wins over a direct write;
    // software is expected not to make them collide at all.
    assign dir_wr   = i_reg_wr && addr_hit && !op_upd;

    // Drive the calculator
    assign alu_link.op       = i_op_valid ? i_op : CSF_OP_NOP;
    assign alu_link.opnd_a   = i_opnd_a;
    assign alu_link.opnd_b   = i_opnd_b;
    assign alu_link.flags_in = flags;

    csf_alu u_alu (
        .alu (alu_link)
    );

    // Arithmetic flags: operation update first, then direct write
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            arith_q <= CSF_STATUS_RST[7:2];
        end else if (op_upd) begin
            arith_q <= alu_link.flags_out[7:2];
        end else if (dir_wr) begin
            arith_q <= i_reg_wdata[7:2];
        end
    end

    // Fast interrupt status; entry beats return, writes never touch it
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fis_q <= CSF_STATUS_RST[CSF_BIT_FIS];
        end else if (i_fast_int_start) begin
            fis_q <= 1'b1;
        end else if (i_int_return) begin
            fis_q <= 1'b0;
        end
    end

    // Fast return is requested only when a return meets a set status
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fast_ret_q <= 1'b0;
        end else begin
            fast_ret_q <= i_int_return && fis_q;
        end
    end

    // Page select: dedicated ops beat a direct write
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            page_q <= CSF_STATUS_RST[CSF_BIT_PG];
        end else if (i_sel_page1) begin
            page_q <= 1'b1;
        end else if (i_sel_page0) begin
            page_q <= 1'b0;
        end else if (dir_wr) begin
            page_q <= i_reg_wdata[CSF_BIT_PG];
        end
    end

    // Result register toward the register file
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            result_q    <= 8'h00;
            result_wr_q <= 1'b0;
        end else begin
            result_q    <= alu_link.result;
            result_wr_q <= i_op_valid && alu_link.res_wr;
        end
    end

    // Read port: one cycle latency, zero when another address is read
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q <= 8'h00;
        end else if (i_reg_rd) begin
            rdata_q <= addr_hit ? flags : 8'h00;
        end
    end

    // Condition test looks only at bits 7..4; the decimal bit is not reachable
    always_comb begin
        case (i_cond)
            CSF_CC_NEVER:  o_cond_true = 1'b0;
            CSF_CC_ALWAYS: o_cond_true = 1'b1;
            CSF_CC_C:      o_cond_true = arith_q[CSF_BIT_C];
            CSF_CC_NC:     o_cond_true = !arith_q[CSF_BIT_C];
            CSF_CC_Z:      o_cond_true = arith_q[CSF_BIT_Z];
            CSF_CC_NZ:     o_cond_true = !arith_q[CSF_BIT_Z];
            CSF_CC_MI:     o_cond_true = arith_q[CSF_BIT_S];
            CSF_CC_PL:     o_cond_true = !arith_q[CSF_BIT_S];
            CSF_CC_OV:     o_cond_true = arith_q[CSF_BIT_V];
            CSF_CC_NOV:    o_cond_true = !arith_q[CSF_BIT_V];
            default:       o_cond_true = 1'b0;
        endcase
    end

    // Outputs
    assign o_result      = result_q;
    assign o_result_wr   = result_wr_q;
    assign o_reg_rdata   = rdata_q;
    assign o_int_block   = fis_q;
    assign o_fast_return = fast_ret_q;
    assign o_page_sel    = page_q;
    assign o_flags       = flags;

    // Reference sums for checking carry and half-carry after add
    logic [8:0] chk_sum;
    logic [4:0] chk_half;
    assign chk_sum  = {1'b0, i_opnd_a} + {1'b0, i_opnd_b};
    assign chk_half = {1'b0, i_opnd_a[3:0]} + {1'b0, i_opnd_b[3:0]};

    carry_add_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_op_valid && i_op == CSF_OP_ADD |=> arith_q[CSF_BIT_C] == $past(chk_sum[8]))
        else $error("carry after add wrong");

    borrow_sub_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_op_valid && i_op == CSF_OP_SUB |=> arith_q[CSF_BIT_C] == ($past(i_opnd_a) < $past(i_opnd_b)))
        else $error("borrow after subtract wrong");

    shift_carry_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_op_valid && (i_op == CSF_OP_RR || i_op == CSF_OP_SRA)
        |=> arith_q[CSF_BIT_C] == $past(i_opnd_a[0]))
        else $error("shift carry not last bit out");

    carry_force_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_op_valid && i_op == CSF_OP_CCF
        |=> arith_q[CSF_BIT_C] != $past(arith_q[CSF_BIT_C]) && $stable(arith_q[6:2]))
        else $error("carry complement disturbed flags");

    zero_sign_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_op_valid && (i_op == CSF_OP_ADD || i_op == CSF_OP_XOR || i_op == CSF_OP_RL)
        |=> arith_q[CSF_BIT_Z] == (o_result == 8'h00) && arith_q[CSF_BIT_S] == o_result[7])
        else $error("zero or sign disagrees with result");

    add_ovf_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_op_valid && i_op == CSF_OP_ADD && i_opnd_a == 8'h7f && i_opnd_b == 8'h01
        |=> arith_q[CSF_BIT_V])
        else $error("overflow missing past positive limit");

    logic_ovf_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_op_valid && (i_op == CSF_OP_AND || i_op == CSF_OP_OR || i_op == CSF_OP_XOR)
        |=> !arith_q[CSF_BIT_V])
        else $error("logic op left overflow set");

    dec_bit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_op_valid && (i_op == CSF_OP_ADD || i_op == CSF_OP_SUB)
        |=> arith_q[CSF_BIT_D] == ($past(i_op) == CSF_OP_SUB))
        else $error("decimal bit wrong after add or subtract");

    half_carry_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_op_valid && i_op == CSF_OP_ADD |=> arith_q[CSF_BIT_H] == $past(chk_half[4]))
        else $error("half carry wrong after add");

    fis_seq_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_fast_int_start || (i_int_return && o_int_block) |=> o_int_block == $past(i_fast_int_start))
        else $error("fast status not set on entry or cleared on return");

    fast_ret_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_int_return |=> o_fast_return == $past(fis_q))
        else $error("fast return not tied to status");

    page_sel_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_sel_page0 && !i_sel_page1 |=> !o_page_sel)
        else $error("page zero op did not clear page bit");

    direct_wr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_reg_wr && addr_hit && !i_op_valid && !i_fast_int_start && !i_int_return
        |=> arith_q == $past(i_reg_wdata[7:2]) && $stable(fis_q))
        else $error("direct write not stored or touched status");

    cond_src_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_cond == CSF_CC_Z |-> o_cond_true == o_flags[CSF_BIT_Z])
        else $error("zero condition not taken from zero bit");

    cov_da_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        i_op_valid && i_op == CSF_OP_ADD ##[1:2] i_op_valid && i_op == CSF_OP_DA);
    cov_fast_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        i_fast_int_start ##[1:20] i_int_return);
    cov_write_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        i_reg_wr && addr_hit ##1 i_reg_rd && addr_hit);

endmodule

// *** pkg/csf_pkg.sv ***
/*
 * Shared constants and types for the CPU status flag block: register
 * address, bit positions, reset value, ALU operations, jump conditions.
 * Assumes one CPU clock domain and an 8-bit register file address.
 */
package csf_pkg;

    // Register file address of the status register
    localparam logic [7:0] CSF_STATUS_ADDR = 8'hd5;

    // Bit positions inside the status register
    localparam int CSF_BIT_C   = 7;
    localparam int CSF_BIT_Z   = 6;
    localparam int CSF_BIT_S   = 5;
    localparam int CSF_BIT_V   = 4;
    localparam int CSF_BIT_D   = 3;
    localparam int CSF_BIT_H   = 2;
    localparam int CSF_BIT_FIS = 1;
    localparam int CSF_BIT_PG  = 0;

    // Reset value; bits 7..2 are don't-care, cleared for determinism
    localparam logic [7:0] CSF_STATUS_RST = 8'h00;

    // Decimal adjust correction constants
    localparam logic [7:0] CSF_DA_LO  = 8'h06;
    localparam logic [7:0] CSF_DA_HI  = 8'h60;
    localparam logic [7:0] CSF_DA_MAX = 8'h99;
    localparam logic [3:0] CSF_NIB_MAX = 4'h9;

    // Operations that the sequencer hands to the flag logic
    typedef enum logic [4:0] {
        CSF_OP_NOP, CSF_OP_ADD, CSF_OP_ADC, CSF_OP_SUB, CSF_OP_SBC,
        CSF_OP_CP,  CSF_OP_AND, CSF_OP_OR,  CSF_OP_XOR, CSF_OP_TM,
        CSF_OP_RL,  CSF_OP_RLC, CSF_OP_RR,  CSF_OP_RRC, CSF_OP_SRA,
        CSF_OP_DA,  CSF_OP_SCF, CSF_OP_RCF, CSF_OP_CCF
    } csf_op_t;

    // Jump conditions; only carry, zero, sign and overflow are offered
    typedef enum logic [3:0] {
        CSF_CC_NEVER, CSF_CC_ALWAYS, CSF_CC_C,  CSF_CC_NC,
        CSF_CC_Z,     CSF_CC_NZ,     CSF_CC_MI, CSF_CC_PL,
        CSF_CC_OV,    CSF_CC_NOV
    } csf_cond_t;

endpackage

// *** pkg/csf_alu_if.sv ***
/*
 * Carrier between the status register core and its flag calculator.
 * Assumes both ends sit in the same clock domain; the path is combinational.
 */
`timescale 1ns/1ps
interface csf_alu_if;
    import csf_pkg::*;

    csf_op_t    op;         // Operation in progress
    logic [7:0] opnd_a;     // Destination operand
    logic [7:0] opnd_b;     // Source operand
    logic [7:0] flags_in;   // Current status register
    logic [7:0] result;     // Computed result
    logic [7:0] flags_out;  // New flag values, bits 7..2 meaningful
    logic       upd;        // Operation changes any flag
    logic       res_wr;     // Result goes back to the destination

    modport core (output op, opnd_a, opnd_b, flags_in,
                  input  result, flags_out, upd, res_wr);
    modport alu  (input  op, opnd_a, opnd_b, flags_in,
                  output result, flags_out, upd, res_wr);
endinterface

// *** verilog/csf_alu.sv ***
/*
 * Flag calculator: combinational result and flag values for one operation.
 * Assumes the core samples the outputs on the clock edge that ends the op.
 */
`timescale 1ns/1ps
module csf_alu
    import csf_pkg::*;
(
    // Link to the status register core
    csf_alu_if.alu alu
);

    // Add with carry in; returns {carry7, carry3, sum}
    function automatic logic [9:0] csf_add(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [4:0] lo;
        logic [8:0] full;
        lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        return {full[8], lo[4], full[7:0]};
    endfunction

    logic       sub;      // Subtract family, borrow sense
    logic [7:0] b_eff;    // Source, inverted for subtract
    logic       cin;      // Carry into bit 0
    logic [9:0] sum;      // Adder output
    logic [7:0] da_adj;   // Decimal adjust correction
    logic       da_c;     // Carry after decimal adjust
    logic       cf;       // Current carry

    // Adder set-up shared by add, subtract and compare
    always_comb begin
        cf    = alu.flags_in[CSF_BIT_C];
        sub   = (alu.op == CSF_OP_SUB) || (alu.op == CSF_OP_SBC) || (alu.op == CSF_OP_CP);
        b_eff = sub ? ~alu.opnd_b : alu.opnd_b;
        if (alu.op == CSF_OP_ADC) begin
            cin = cf;
        end else if (alu.op == CSF_OP_SBC) begin
            cin = ~cf;
        end else begin
            cin = sub;
        end
        sum = csf_add(alu.opnd_a, b_eff, cin);
    end

    // Decimal correction chosen by the D and H flags
    always_comb begin
        da_adj = 8'h00;
        da_c   = cf;
        if (!alu.flags_in[CSF_BIT_D]) begin
            // After an addition
            if (cf || (alu.opnd_a > CSF_DA_MAX)) begin
                da_adj = CSF_DA_HI;
                da_c   = 1'b1;
            end
            if (alu.flags_in[CSF_BIT_H] || (alu.opnd_a[3:0] > CSF_NIB_MAX)) begin
                da_adj = da_adj | CSF_DA_LO;
            end
        end else begin
            // After a subtraction the correction is subtracted
            if (cf) begin
                da_adj = CSF_DA_HI;
            end
            if (alu.flags_in[CSF_BIT_H]) begin
                da_adj = da_adj | CSF_DA_LO;
            end
        end
    end

    // Result and flags for each operation
    always_comb begin
        alu.result    = alu.opnd_a;
        alu.flags_out = alu.flags_in;
        alu.upd       = 1'b1;
        alu.res_wr    = 1'b1;
        case (alu.op)
            CSF_OP_ADD, CSF_OP_ADC, CSF_OP_SUB, CSF_OP_SBC, CSF_OP_CP: begin
                alu.result               = sum[7:0];
                alu.flags_out[CSF_BIT_C] = sum[9] ^ sub;
                alu.flags_out[CSF_BIT_H] = sum[8] ^ sub;
                alu.flags_out[CSF_BIT_V] = (alu.opnd_a[7] == b_eff[7]) && (sum[7] != alu.opnd_a[7]);
                alu.flags_out[CSF_BIT_D] = sub;
                alu.res_wr               = (alu.op != CSF_OP_CP);
            end
            CSF_OP_AND, CSF_OP_TM: begin
                alu.result               = alu.opnd_a & alu.opnd_b;
                alu.flags_out[CSF_BIT_V] = 1'b0;
                alu.res_wr               = (alu.op == CSF_OP_AND);
            end
            CSF_OP_OR: begin
                alu.result               = alu.opnd_a | alu.opnd_b;
                alu.flags_out[CSF_BIT_V] = 1'b0;
            end
            CSF_OP_XOR: begin
                alu.result               = alu.opnd_a ^ alu.opnd_b;
                alu.flags_out[CSF_BIT_V] = 1'b0;
            end
            CSF_OP_RL, CSF_OP_RLC: begin
                alu.result = {alu.opnd_a[6:0], (alu.op == CSF_OP_RL) ? alu.opnd_a[7] : cf};
                alu.flags_out[CSF_BIT_C] = alu.opnd_a[7];
                alu.flags_out[CSF_BIT_V] = alu.opnd_a[7] ^ alu.opnd_a[6];
            end
            CSF_OP_RR, CSF_OP_RRC, CSF_OP_SRA: begin
                alu.result = {(alu.op == CSF_OP_RR) ? alu.opnd_a[0] :
                              (alu.op == CSF_OP_RRC) ? cf : alu.opnd_a[7], alu.opnd_a[7:1]};
                alu.flags_out[CSF_BIT_C] = alu.opnd_a[0];
                alu.flags_out[CSF_BIT_V] = (alu.op == CSF_OP_SRA) ? 1'b0 : (alu.opnd_a[7] ^ alu.result[7]);
            end
            CSF_OP_DA: begin
                alu.result = alu.flags_in[CSF_BIT_D] ? (alu.opnd_a - da_adj) : (alu.opnd_a + da_adj);
                alu.flags_out[CSF_BIT_C] = da_c;
            end
            CSF_OP_SCF: begin
                alu.flags_out[CSF_BIT_C] = 1'b1;
                alu.res_wr               = 1'b0;
            end
            CSF_OP_RCF: begin
                alu.flags_out[CSF_BIT_C] = 1'b0;
                alu.res_wr               = 1'b0;
            end
            CSF_OP_CCF: begin
                alu.flags_out[CSF_BIT_C] = ~cf;
                alu.res_wr               = 1'b0;
            end
            default: begin
                // No operation leaves everything alone
                alu.upd    = 1'b0;
                alu.res_wr = 1'b0;
            end
        endcase
        // Zero and sign come from any result-producing operation
        if (alu.upd && (alu.op != CSF_OP_SCF) && (alu.op != CSF_OP_RCF) && (alu.op != CSF_OP_CCF)) begin
            alu.flags_out[CSF_BIT_Z] = (alu.result == 8'h00);
            alu.flags_out[CSF_BIT_S] = alu.result[7];
        end
    end

endmodule

// *** verification/csf_seq_model.sv ***
/*
 * Sequencer-side model: passes register writes to the flag block.
 * Assumes the bench drives its requests on the CPU clock.
 */
`timescale 1ns/1ps
module csf_seq_model
    import csf_pkg::*;
(
    // Requests from the bench
    input  wire logic       i_op_valid,
    input  wire csf_op_t    i_op,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    // Write strobe to the flag block
    output logic            o_reg_wr
);
    // Software never aims a flag-changing op at the status register
    assign o_reg_wr = i_reg_wr && !(i_op_valid && i_op != CSF_OP_NOP && i_reg_addr == CSF_STATUS_ADDR);
endmodule

// *** verification/tb_csf_status_flags.sv ***
/*
 * Self-checking bench for the flag block: random ops with corner cases,
 * register access, interrupt, page and jump condition checks.
 * Assumes a 10 MHz clock and the sequencer model in front of the writes.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin errors++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module tb_csf_status_flags;
    import csf_pkg::*;
    logic        i_clk = 0, i_rst_n = 0, i_op_valid = 0, i_reg_wr = 0, i_reg_rd = 0, wr_gated;
    logic        i_fast_int_start = 0, i_int_return = 0, i_sel_page0 = 0, i_sel_page1 = 0;
    csf_op_t     i_op = CSF_OP_NOP;
    csf_cond_t   i_cond = CSF_CC_NEVER;
    logic [7:0]  i_opnd_a = 0, i_opnd_b = 0, i_reg_addr = 0, i_reg_wdata = 0, o_result, o_reg_rdata, o_flags;
    logic        o_result_wr, o_int_block, o_fast_return, o_page_sel, o_cond_true;
    logic [7:0]  fm;                 // Flags as the bench expects them
    logic [15:0] seed = 16'h0a8f;    // Fixed seed keeps runs repeatable
    int          errors = 0, n_tests = 0;
    csf_op_t     tbl [18] = '{CSF_OP_ADD, CSF_OP_SUB, CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR, CSF_OP_SCF,
                              CSF_OP_RCF, CSF_OP_CCF, CSF_OP_RL, CSF_OP_RR, CSF_OP_SRA, CSF_OP_RLC,
                              CSF_OP_ADC, CSF_OP_SBC, CSF_OP_CP, CSF_OP_TM, CSF_OP_RRC, CSF_OP_DA};
    always #50 i_clk = ~i_clk;
    csf_seq_model u_csf_seq_model (.i_op_valid(i_op_valid), .i_op(i_op), .i_reg_addr(i_reg_addr),
                                   .i_reg_wr(i_reg_wr), .o_reg_wr(wr_gated));
    csf_status_flags u_csf_status_flags (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_op_valid(i_op_valid), .i_op(i_op),
        .i_opnd_a(i_opnd_a), .i_opnd_b(i_opnd_b), .o_result(o_result), .o_result_wr(o_result_wr),
        .i_reg_addr(i_reg_addr), .i_reg_wr(wr_gated), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .i_fast_int_start(i_fast_int_start), .i_int_return(i_int_return),
        .i_sel_page0(i_sel_page0), .i_sel_page1(i_sel_page1), .o_int_block(o_int_block),
        .o_fast_return(o_fast_return), .o_page_sel(o_page_sel), .i_cond(i_cond), .o_cond_true(o_cond_true),
        .o_flags(o_flags));
    // Xorshift source for operands and op choice
    function automatic logic [15:0] rnd();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed;
    endfunction
    // Expected {flags, result}; shifts leave D and H to the caller's mask
    function automatic logic [15:0] expect_op(csf_op_t op, logic [7:0] a, logic [7:0] b, logic [7:0] f);
        logic [8:0] s;
        logic [7:0] n, adj;
        logic       ci, hi, lo;
        n = f;
        s = {1'h0, a};
        // Carry in for the with-carry ops; decimal correction after add or subtract
        ci = f[7] && (op == CSF_OP_ADC || op == CSF_OP_SBC);
        hi = f[7] || (!f[3] && a > 8'h99);
        lo = f[2] || (!f[3] && a[3:0] > 4'h9);
        adj = (hi ? 8'h60 : 8'h00) | (lo ? 8'h06 : 8'h00);
        case (op)
            CSF_OP_ADD, CSF_OP_ADC: begin s = a + b + ci; n[3] = 0; n[2] = (a[3:0] + b[3:0] + ci) > 5'h0f;
                n[4] = a[7] == b[7] && s[7] != a[7]; end
            CSF_OP_SUB, CSF_OP_SBC, CSF_OP_CP: begin s = a - b - ci; n[3] = 1; n[2] = {1'b0, a[3:0]} < b[3:0] + ci;
                n[4] = a[7] != b[7] && s[7] != a[7]; end
            CSF_OP_AND, CSF_OP_TM: begin s = {f[7], a & b}; n[4] = 0; end
            CSF_OP_OR:  begin s = {f[7], a | b}; n[4] = 0; end
            CSF_OP_XOR: begin s = {f[7], a ^ b}; n[4] = 0; end
            CSF_OP_RRC: begin s = {a[0], f[7], a[7:1]}; n[4] = a[7] ^ f[7]; end
            CSF_OP_RL:  begin s = {a[7], a[6:0], a[7]}; n[4] = a[6] ^ a[7]; end
            CSF_OP_RLC: begin s = {a[7], a[6:0], f[7]}; n[4] = a[6] ^ a[7]; end
            CSF_OP_RR:  begin s = {a[0], a[0], a[7:1]}; n[4] = a[0] ^ a[7]; end
            CSF_OP_SRA: begin s = {a[0], a[7], a[7:1]}; n[4] = 0; end
            CSF_OP_DA:  begin s = f[3] ? a - adj : a + adj; s[8] = hi; end
            default:    s[8] = (op == CSF_OP_SCF) || (op == CSF_OP_CCF && !f[7]);
        endcase
        n[7] = s[8];
        if (op < CSF_OP_SCF) begin
            n[6] = s[7:0] == 8'h00;
            n[5] = s[7];
        end
        return {n, s[7:0]};
    endfunction
    // One operation with a random jump condition; checks flags, result and condition
    task automatic do_op(csf_op_t op, logic [7:0] a, logic [7:0] b, logic [7:0] msk);
        logic [15:0] e;
        e = expect_op(op, a, b, fm);
        @(posedge i_clk);
        i_op_valid <= 1;
        i_op <= op;
        i_opnd_a <= a;
        i_opnd_b <= b;
        i_cond <= csf_cond_t'(rnd() % 10);
        @(posedge i_clk);
        i_op_valid <= 0;
        fm = e[15:8];
        #1 `CHK("flags", fm & msk, o_flags & msk)
        if (op < CSF_OP_SCF) `CHK("result", e[7:0], o_result)
        `CHK("result_wr", op < CSF_OP_SCF && op != CSF_OP_CP && op != CSF_OP_TM, o_result_wr)
        `CHK("cond", i_cond == CSF_CC_ALWAYS || (i_cond > 1 && fm[7 - (i_cond - 2) / 2] ^ i_cond[0]), o_cond_true)
    endtask
    // Register file access, write or read
    task automatic reg_acc(logic [7:0] adr, logic wr, logic [7:0] d);
        @(posedge i_clk);
        i_reg_addr <= adr;
        i_reg_wr <= wr;
        i_reg_rd <= !wr;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 0;
        i_reg_rd <= 0;
        #1;
    endtask
    task automatic close_out();
        if (errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog sized well above the few hundred cycles the tests take
    initial begin
        repeat (5000) @(posedge i_clk);
        errors++;
        close_out();
    end
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1;
        #1 `CHK("rst flags", 8'h00, o_flags)
        reg_acc(CSF_STATUS_ADDR, 1, 8'hff);
        fm = 8'hfd;
        `CHK("wr flags", fm, o_flags)
        reg_acc(CSF_STATUS_ADDR, 0, 8'h00);
        `CHK("rdata", fm, o_reg_rdata)
        reg_acc(8'h10, 0, 8'h00);
        `CHK("rdata other", 8'h00, o_reg_rdata)
        do_op(CSF_OP_ADD, 8'h7f, 8'h01, 8'hfc);
        do_op(CSF_OP_SUB, 8'h80, 8'h01, 8'hfc);
        do_op(CSF_OP_ADD, 8'h15, 8'h27, 8'hfc);
        do_op(CSF_OP_DA, 8'h3c, 8'h00, 8'hfc);
        for (int i = 0; i < 80; i++) begin
            csf_op_t op;
            op = tbl[rnd() % 18];
            do_op(op, 8'(rnd()), 8'(rnd()), op >= CSF_OP_RL ? 8'hf0 : 8'hfc);
        end
        // Fast interrupt entry, return, then a return with the status already clear
        @(posedge i_clk) i_fast_int_start <= 1;
        @(posedge i_clk) i_fast_int_start <= 0;
        #1 `CHK("int_block", 1'b1, o_int_block)
        for (int k = 0; k < 2; k++) begin
            @(posedge i_clk) i_int_return <= 1;
            @(posedge i_clk) i_int_return <= 0;
            #1 `CHK("fast_return", k == 0, o_fast_return)
            `CHK("fis", 1'b0, o_flags[1])
        end
        // Page select ops clear then set the page bit, so each op changes it
        for (int k = 0; k < 2; k++) begin
            @(posedge i_clk);
            i_sel_page1 <= k == 1;
            i_sel_page0 <= k == 0;
            @(posedge i_clk);
            i_sel_page1 <= 0;
            i_sel_page0 <= 0;
            #1 `CHK("page", k == 1, o_page_sel)
            `CHK("page bit", k == 1, o_flags[0])
        end
        // Reset in mid-run, with fast status and page bit set, clears the register
        @(posedge i_clk) i_fast_int_start <= 1;
        @(posedge i_clk) i_fast_int_start <= 0;
        @(posedge i_clk) i_rst_n <= 0;
        #1 `CHK("rst mid flags", 8'h00, o_flags)
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1;
        @(posedge i_clk);
        #1 `CHK("rst mid int_block", 1'b0, o_int_block)
        close_out();
    end
endmodule
